//--- hdl/cpt_regs.sv
`timescale 1ns/100ps
// How it works
// - Writing one to reset bit restores marked defaults, restarts safety timer, self-clears.
// - Cool scale codes: none, 20%, 50%, 100%; default 20%.
// - Warm scale codes same coding; default 100%.
// - Full-current code in a range disables safety timer doubling there.
// - Cool threshold select: 70.75, 68.25 default, 65.25, 62.25 percent.
// - Warm threshold select: 48.25, 44.75 default, 40.75, 37.75 percent.
// - Thermal register resets 0x75; watchdog restores all, command restores marked.
// - Watchdog expiry enters default mode and sets a status flag.
module cpt_regs #(
    parameter logic [3:0] PART_CODE = 4'h3 // Arbitrary neutral value
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register access
    input wire cpt_pkg::cpt_req_type req_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    // Watchdog
    input wire logic wdog_expire_in,
    input wire logic wdog_flag_clr_in,
    output logic wdog_fault_out,
    // Controls to the charger
    output logic safety_timer_restart_out,
    output cpt_pkg::cpt_ctl_type ctl_out
);
    import cpt_pkg::*;

    // Percentage for a scale code
    function automatic logic [6:0] scale_pct(input logic [1:0] code);
        unique case (code)
            CPT_SCALE_NONE: scale_pct = 7'd0;
            CPT_SCALE_20: scale_pct = 7'd20;
            CPT_SCALE_50: scale_pct = 7'd50;
            CPT_SCALE_FULL: scale_pct = 7'd100;
        endcase
    endfunction : scale_pct

    typedef struct packed {
        logic [7:0] thermal;
        logic [7:0] rdata;
        logic rvalid;
        logic wdog_fault;
        logic timer_restart;
        logic [6:0] cool_pct;
        logic [6:0] warm_pct;
        logic cool_dbl;
        logic warm_dbl;
    } cpt_state_type;

    cpt_state_type state_r;
    cpt_state_type state_nxt;
    logic [12:0] cool_thr;
    logic [12:0] warm_thr;
    logic rst_cmd;
    logic [7:0] part_val;

    assign rst_cmd = req_in.wr && req_in.addr == CPT_ADDR_PART_INFO
        && req_in.data[CPT_RST_CMD_BIT];
    // Reset bit always reads zero; fixed code and reserved bits
    assign part_val = {1'b0, PART_CODE, CPT_PART_RSVD_VAL};

    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = 1'b0;
        state_nxt.timer_restart = 1'b0;
        // Host write to thermal register
        if (req_in.wr && req_in.addr == CPT_ADDR_THERMAL) begin
            state_nxt.thermal = req_in.data;
        end
        if (rst_cmd) begin
            state_nxt.thermal = (state_r.thermal & ~CPT_THERMAL_CMD_MASK)
                | (CPT_THERMAL_RESET & CPT_THERMAL_CMD_MASK);
            state_nxt.timer_restart = 1'b1;
        end
        if (wdog_flag_clr_in) begin
            state_nxt.wdog_fault = 1'b0;
        end
        if (wdog_expire_in) begin
            state_nxt.thermal = CPT_THERMAL_RESET;
            state_nxt.wdog_fault = 1'b1;
        end
        if (req_in.rd) begin
            state_nxt.rvalid = 1'b1;
            unique case (req_in.addr)
                CPT_ADDR_PART_INFO: state_nxt.rdata = part_val;
                CPT_ADDR_THERMAL: state_nxt.rdata = state_r.thermal;
                default: state_nxt.rdata = 8'h00;
            endcase
        end
        state_nxt.cool_pct = scale_pct(state_nxt.thermal[CPT_COOL_SCALE_LSB +: 2]);
        state_nxt.warm_pct = scale_pct(state_nxt.thermal[CPT_WARM_SCALE_LSB +: 2]);
        state_nxt.cool_dbl = state_nxt.thermal[CPT_COOL_SCALE_LSB +: 2] != CPT_SCALE_FULL;
        state_nxt.warm_dbl = state_nxt.thermal[CPT_WARM_SCALE_LSB +: 2] != CPT_SCALE_FULL;
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= '{thermal: CPT_THERMAL_RESET, rdata: 8'h00, rvalid: 1'b0,
                wdog_fault: 1'b0, timer_restart: 1'b0, cool_pct: 7'd20,
                warm_pct: 7'd100, cool_dbl: 1'b1, warm_dbl: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    cpt_thr_lut u_lut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cool_sel_in(state_r.thermal[CPT_COOL_THR_LSB +: 2]),
        .warm_sel_in(state_r.thermal[CPT_WARM_THR_LSB +: 2]),
        .cool_thr_out(cool_thr),
        .warm_thr_out(warm_thr)
    );

    // Outputs
    assign rdata_out = state_r.rdata;
    assign rvalid_out = state_r.rvalid;
    assign wdog_fault_out = state_r.wdog_fault;
    assign safety_timer_restart_out = state_r.timer_restart;
    assign ctl_out = '{cool_pct: state_r.cool_pct, warm_pct: state_r.warm_pct,
        cool_timer_double: state_r.cool_dbl, warm_timer_double: state_r.warm_dbl,
        cool_thr: cool_thr, warm_thr: warm_thr};

    // Assertions
    property p_cmd_restart;
        @(posedge clk_in) disable iff (rst_in) rst_cmd |=> safety_timer_restart_out;
    endproperty
    a_cmd_restart: assert property (p_cmd_restart) else $error("no timer restart");
    property p_cmd_defaults;
        @(posedge clk_in) disable iff (rst_in)
        rst_cmd && !wdog_expire_in |=> (state_r.thermal & CPT_THERMAL_CMD_MASK) == 8'h75;
    endproperty
    a_cmd_defaults: assert property (p_cmd_defaults) else $error("cmd defaults wrong");
    property p_cool_pct;
        @(posedge clk_in) disable iff (rst_in)
        state_r.thermal[7:6] == 2'h1 |-> state_r.cool_pct == 7'd20;
    endproperty
    a_cool_pct: assert property (p_cool_pct) else $error("cool pct wrong");
    property p_warm_pct;
        @(posedge clk_in) disable iff (rst_in)
        state_r.thermal[5:4] == 2'h2 |-> state_r.warm_pct == 7'd50;
    endproperty
    a_warm_pct: assert property (p_warm_pct) else $error("warm pct wrong");
    property p_no_double;
        @(posedge clk_in) disable iff (rst_in)
        state_r.thermal[5:4] == 2'h3 |-> !ctl_out.warm_timer_double;
    endproperty
    a_no_double: assert property (p_no_double) else $error("timer doubled");
    property p_cool_thr;
        @(posedge clk_in) disable iff (rst_in)
        state_r.thermal[3:2] == 2'h0 ##1 $stable(state_r.thermal) |-> cool_thr == 13'd7075;
    endproperty
    a_cool_thr: assert property (p_cool_thr) else $error("cool thr wrong");
    property p_warm_thr;
        @(posedge clk_in) disable iff (rst_in)
        state_r.thermal[1:0] == 2'h3 ##1 $stable(state_r.thermal) |-> warm_thr == 13'd3775;
    endproperty
    a_warm_thr: assert property (p_warm_thr) else $error("warm thr wrong");
    property p_wdog;
        @(posedge clk_in) disable iff (rst_in)
        wdog_expire_in |=> state_r.thermal == 8'h75 && wdog_fault_out;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog defaults wrong");
    property p_part_ro;
        @(posedge clk_in) disable iff (rst_in)
        req_in.rd && req_in.addr == CPT_ADDR_PART_INFO |=> rdata_out == {1'b0, PART_CODE, 3'h4};
    endproperty
    a_part_ro: assert property (p_part_ro) else $error("part info changed");
    property p_rvalid;
        @(posedge clk_in) disable iff (rst_in)
        req_in.rd |=> rvalid_out;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_part_wr_ignored;
        @(posedge clk_in) disable iff (rst_in)
        req_in.wr && req_in.addr == CPT_ADDR_PART_INFO && !req_in.data[CPT_RST_CMD_BIT]
            && !wdog_expire_in |=> $stable(state_r.thermal);
    endproperty
    a_part_wr_ignored: assert property (p_part_wr_ignored) else $error("part write leaked");
    property p_cmd_keep;
        @(posedge clk_in) disable iff (rst_in)
        rst_cmd && !wdog_expire_in |=> (state_r.thermal & ~CPT_THERMAL_CMD_MASK)
            == ($past(state_r.thermal) & ~CPT_THERMAL_CMD_MASK);
    endproperty
    a_cmd_keep: assert property (p_cmd_keep) else $error("unmarked bits changed");
    property p_fault_hold;
        @(posedge clk_in) disable iff (rst_in)
        wdog_fault_out && !wdog_flag_clr_in |=> wdog_fault_out;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");
    property p_cool_full;
        @(posedge clk_in) disable iff (rst_in)
        state_r.thermal[7:6] == 2'h3 |-> !ctl_out.cool_timer_double;
    endproperty
    a_cool_full: assert property (p_cool_full) else $error("cool timer doubled");
    property p_cool_none;
        @(posedge clk_in) disable iff (rst_in)
        state_r.thermal[7:6] == 2'h0 |-> ctl_out.cool_pct == 7'd0;
    endproperty
    a_cool_none: assert property (p_cool_none) else $error("cool charge not stopped");
    property p_warm_none;
        @(posedge clk_in) disable iff (rst_in)
        state_r.thermal[5:4] == 2'h0 |-> ctl_out.warm_pct == 7'd0;
    endproperty
    a_warm_none: assert property (p_warm_none) else $error("warm charge not stopped");
    // Main scenarios
    c_cmd: cover property (@(posedge clk_in) rst_cmd);
    c_rd_part: cover property (@(posedge clk_in) req_in.rd && req_in.addr == CPT_ADDR_PART_INFO);
    c_wdog_clr: cover property (@(posedge clk_in) wdog_expire_in && wdog_flag_clr_in);
    c_wdog: cover property (@(posedge clk_in) wdog_expire_in);
    c_wr: cover property (@(posedge clk_in) req_in.wr && req_in.addr == CPT_ADDR_THERMAL);
endmodule : cpt_regs

//--- hdl/cpt_pkg.sv
package cpt_pkg;
    // Register addresses
    localparam logic [7:0] CPT_ADDR_PART_INFO = 8'h0b;
    localparam logic [7:0] CPT_ADDR_THERMAL = 8'h0c;
    // Part info layout
    localparam int CPT_RST_CMD_BIT = 7;
    localparam int CPT_PART_CODE_LSB = 3;
    localparam int CPT_PART_CODE_W = 4;
    localparam logic [2:0] CPT_PART_RSVD_VAL = 3'h4;
    // Thermal profile layout
    localparam int CPT_COOL_SCALE_LSB = 6;
    localparam int CPT_WARM_SCALE_LSB = 4;
    localparam int CPT_COOL_THR_LSB = 2;
    localparam int CPT_WARM_THR_LSB = 0;
    localparam logic [7:0] CPT_THERMAL_RESET = 8'h75;
    // Bits restored by register-reset command (others only by watchdog or rst_in)
    localparam logic [7:0] CPT_THERMAL_CMD_MASK = 8'hf5;
    // Scale codes
    localparam logic [1:0] CPT_SCALE_NONE = 2'h0;
    localparam logic [1:0] CPT_SCALE_20 = 2'h1;
    localparam logic [1:0] CPT_SCALE_50 = 2'h2;
    localparam logic [1:0] CPT_SCALE_FULL = 2'h3;
    // Threshold ratios in hundredths of a percent
    localparam logic [12:0] CPT_COOL_THR_0 = 13'd7075;
    localparam logic [12:0] CPT_COOL_THR_1 = 13'd6825;
    localparam logic [12:0] CPT_COOL_THR_2 = 13'd6525;
    localparam logic [12:0] CPT_COOL_THR_3 = 13'd6225;
    localparam logic [12:0] CPT_WARM_THR_0 = 13'd4825;
    localparam logic [12:0] CPT_WARM_THR_1 = 13'd4475;
    localparam logic [12:0] CPT_WARM_THR_2 = 13'd4075;
    localparam logic [12:0] CPT_WARM_THR_3 = 13'd3775;

    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } cpt_req_type;

    // Decoded thermal profile controls
    typedef struct packed {
        logic [6:0] cool_pct;
        logic [6:0] warm_pct;
        logic cool_timer_double;
        logic warm_timer_double;
        logic [12:0] cool_thr;
        logic [12:0] warm_thr;
    } cpt_ctl_type;
endpackage : cpt_pkg

//--- hdl/cpt_thr_lut.sv
`timescale 1ns/100ps
// Registered threshold lookup for both thermistor ratio selects
module cpt_thr_lut (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Selects
    input wire logic [1:0] cool_sel_in,
    input wire logic [1:0] warm_sel_in,
    // Ratios
    output logic [12:0] cool_thr_out,
    output logic [12:0] warm_thr_out
);
    import cpt_pkg::*;

    typedef struct packed {
        logic [12:0] cool;
        logic [12:0] warm;
    } cpt_lut_state_type;

    cpt_lut_state_type state_r;
    cpt_lut_state_type state_nxt;

    // Table lookup
    always_comb begin
        state_nxt = state_r;
        unique case (cool_sel_in)
            2'h0: state_nxt.cool = CPT_COOL_THR_0;
            2'h1: state_nxt.cool = CPT_COOL_THR_1;
            2'h2: state_nxt.cool = CPT_COOL_THR_2;
            2'h3: state_nxt.cool = CPT_COOL_THR_3;
        endcase
        unique case (warm_sel_in)
            2'h0: state_nxt.warm = CPT_WARM_THR_0;
            2'h1: state_nxt.warm = CPT_WARM_THR_1;
            2'h2: state_nxt.warm = CPT_WARM_THR_2;
            2'h3: state_nxt.warm = CPT_WARM_THR_3;
        endcase
    end

    // Output register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= '{cool: CPT_COOL_THR_1, warm: CPT_WARM_THR_1};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cool_thr_out = state_r.cool;
    assign warm_thr_out = state_r.warm;
endmodule : cpt_thr_lut

//--- verif/cpt_host.sv
`timescale 1ns/100ps
// Host model issuing register requests
module cpt_host (
    // Clock
    input wire logic clk_in,
    // Answer
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    // Requests
    output cpt_pkg::cpt_req_type req_out
);
    import cpt_pkg::*;
    initial req_out = '0;
    // Write pulse; idle fields show inverted values
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{1'b1, 1'b0, a, d};
        @(posedge clk_in);
        req_out <= '{1'b0, 1'b0, ~a, ~d};
    endtask : write
    // Read pulse; answer taken one cycle later
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_in);
        req_out <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_in);
        req_out <= '{1'b0, 1'b0, ~a, 8'hff};
        #1;
        ok = rvalid_in;
        d = rdata_in;
    endtask : read
endmodule : cpt_host

//--- verif/tb.sv
`timescale 1ns/100ps
module tb;
    import cpt_pkg::*;
    localparam logic [3:0] PC = 4'h9; // Arbitrary part code
    logic clk_in, rst_in, wd_exp, wd_clr, rvalid, restart, fault, ok;
    logic [7:0] rdata, rd, th;
    cpt_req_type req;
    cpt_ctl_type ctl;
    int mismatches = 0, checked = 0, cyc = 0, i;
    cpt_host host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
    cpt_regs #(.PART_CODE(PC)) DUT (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
        .rdata_out(rdata), .rvalid_out(rvalid), .wdog_expire_in(wd_exp),
        .wdog_flag_clr_in(wd_clr), .wdog_fault_out(fault),
        .safety_timer_restart_out(restart), .ctl_out(ctl));
    // Clock and timeout
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [6:0] pct(input logic [1:0] c);
        return (c == 2'h0) ? 7'd0 : (c == 2'h1) ? 7'd20 : (c == 2'h2) ? 7'd50 : 7'd100;
    endfunction : pct
    // Write with model update and restart pulse check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write(a, d);
        if (a == 8'h0c) th = d;
        if (a == 8'h0b && d[7]) th = (th & ~CPT_THERMAL_CMD_MASK) | (8'h75 & CPT_THERMAL_CMD_MASK);
        #1;
        chk(restart, a == 8'h0b && d[7]);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.read(a, rd, ok);
        chk(ok, 1);
        chk(rd, e);
    endtask : rdchk
    // Decoded controls against the model
    task automatic ctlchk();
        logic [12:0] ct [4] = '{13'd7075, 13'd6825, 13'd6525, 13'd6225};
        logic [12:0] wt [4] = '{13'd4825, 13'd4475, 13'd4075, 13'd3775};
        repeat (2) @(posedge clk_in);
        #1;
        chk(ctl.cool_pct, pct(th[7:6]));
        chk(ctl.warm_pct, pct(th[5:4]));
        chk(ctl.cool_timer_double, th[7:6] != 2'h3);
        chk(ctl.warm_timer_double, th[5:4] != 2'h3);
        chk(ctl.cool_thr, ct[th[3:2]]);
        chk(ctl.warm_thr, wt[th[1:0]]);
    endtask : ctlchk
    task automatic pulse(input logic e, input logic c);
        @(posedge clk_in);
        wd_exp <= e;
        wd_clr <= c;
        @(posedge clk_in);
        wd_exp <= 1'b0;
        wd_clr <= 1'b0;
        #1;
    endtask : pulse
    initial begin
        clk_in = 0;
        rst_in = 1;
        wd_exp = 0;
        wd_clr = 0;
        th = 8'h75;
        void'($urandom(71));
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rdchk(8'h0c, 8'h75);
        rdchk(8'h0b, {1'b0, PC, 3'h4});
        ctlchk();
        $display("test reset done");
        for (i = 0; i < 10; i++) begin
            wr(8'h0c, i < 4 ? {4{i[1:0]}} : 8'($urandom));
            rdchk(8'h0c, th);
            ctlchk();
        end
        $display("test codes done");
        wr(8'h0b, 8'h7f);
        rdchk(8'h0b, {1'b0, PC, 3'h4});
        wr(8'h33, 8'h00);
        rdchk(8'h33, 8'h00);
        rdchk(8'h0c, th);
        $display("test read only done");
        wr(8'h0c, 8'h0a);
        wr(8'h0b, 8'hff);
        rdchk(8'h0b, {1'b0, PC, 3'h4});
        rdchk(8'h0c, th);
        ctlchk();
        $display("test command done");
        wr(8'h0c, 8'h3a);
        pulse(1'b1, 1'b0);
        th = 8'h75;
        chk(fault, 1);
        rdchk(8'h0c, th);
        ctlchk();
        pulse(1'b1, 1'b1);
        chk(fault, 1);
        pulse(1'b0, 1'b1);
        chk(fault, 0);
        $display("test watchdog done");
        conclude();
    end
endmodule : tb
